/* rtl/dsamc_ctrl.sv */
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - refresh generated internally, CBR or auto-refresh
// - row and column from 23-bit address
// - column width programmable 8 to 11
// - EDO read data latched later
// - mode register key: CL2, BL1, sequential
// - leftover address bits act as SDRAM bank select
// - bank bit 0 selects EDO or fast page
// - system config selects async DRAM or SDRAM
// - per-bank tCS (async DRAM only), tCP, tRCD, tRP applied
// - drive SDRAM clock, enable, selects, strobes, masks
// - 8-bit column phase pin mapping
// - 8-bit row phase pin mapping
// - 9-bit column phase pin mapping
// - 9-bit row phase pin mapping
// - 10-bit column phase pin mapping
// - 10-bit row phase pin mapping
// - internal address scaled to memory width
// - column width field in bits 31:30
// - config bit 31 makes all banks SDRAM
module dsamc_ctrl (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// internal memory request
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [1:0]  mem_bank,
	input  wire logic [24:0] mem_byte_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [3:0]  mem_be,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack,
	// memory pins
	output logic      [21:0] mem_addr_pins,
	input  wire logic [31:0] mem_data_in,
	output logic      [31:0] mem_data_out,
	output logic             mem_data_oe,
	output logic             mem_write_en_n,
	output logic      [3:0]  dram_row_strobe_n,
	output logic             dram_col_strobe_n,
	output logic             sdram_clock_out,
	output logic             sdram_clock_enable,
	output logic      [3:0]  sdram_chip_select_n,
	output logic             sdram_row_strobe_n,
	output logic             sdram_col_strobe_n,
	output logic      [3:0]  sdram_byte_mask
);
	// ==========================================================
	// address mux: row/col phase by column width
	function automatic logic [14:0] mux_addr(input logic [22:0] a, input logic [1:0] can,
		input logic row, input logic ap);
		logic [14:0] r;
		r = 15'h0000;
		if (row) begin
			// top bits left over above the row feed sdram bank select
			r = a[22:8] >> can;
		end else begin
			r[14:11] = a[22:19] >> can;
			r[10]    = ap;
			r[9:0]   = a[9:0];
		end
		return r;
	endfunction

	// ==========================================================
	// registers
	logic [31:0] bank_ctl_q [4];
	logic [31:0] sys_cfg_q;
	logic [31:0] ref_ctl_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        mrs_pend_q;
	logic        apb_wr;
	logic        sel_bank;
	logic [1:0]  bank_idx;
	logic        mapped;
	logic [15:0] bank_ofs;

	assign bank_ofs = paddr - dsamc_pkg::OFS_BANK_CONTROL0;
	assign bank_idx = bank_ofs[3:2];
	assign sel_bank = (paddr >= dsamc_pkg::OFS_BANK_CONTROL0) && (bank_ofs[15:4] == 12'h000)
		&& (paddr[1:0] == 2'h0);
	assign mapped   = sel_bank || (paddr == dsamc_pkg::OFS_SYSTEM_CONFIG)
		|| (paddr == dsamc_pkg::OFS_REFRESH_EXTIO);
	assign apb_wr   = psel && penable && pready_q && pwrite && mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= dsamc_pkg::RST_ZERO;
		end else begin
			pready_q  <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			if (psel && !penable) begin
				if (sel_bank)
					prdata_q <= bank_ctl_q[bank_idx];
				else if (paddr == dsamc_pkg::OFS_SYSTEM_CONFIG)
					prdata_q <= sys_cfg_q;
				else if (paddr == dsamc_pkg::OFS_REFRESH_EXTIO)
					prdata_q <= ref_ctl_q;
				else
					prdata_q <= dsamc_pkg::RST_ZERO;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++)
				bank_ctl_q[i] <= dsamc_pkg::RST_ZERO;
			sys_cfg_q <= dsamc_pkg::RST_ZERO;
			ref_ctl_q <= dsamc_pkg::RST_ZERO;
		end else if (apb_wr) begin
			if (sel_bank)
				bank_ctl_q[bank_idx] <= pwdata;
			else if (paddr == dsamc_pkg::OFS_SYSTEM_CONFIG)
				sys_cfg_q <= pwdata;
			else
				ref_ctl_q <= pwdata;
		end
	end

	// ==========================================================
	// memory timing tick and sdram clock
	logic tick_q;
	logic sdram_clk_q;
	logic cke_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q      <= 1'b0;
			sdram_clk_q <= 1'b0;
			cke_q       <= 1'b0;
		end else begin
			tick_q      <= !tick_q;
			sdram_clk_q <= tick_q;
			cke_q       <= 1'b1;
		end
	end

	// ==========================================================
	// refresh interval timer
	logic        sdram_mode;
	logic [10:0] ref_cnt_q;
	logic        ref_pend_q;
	logic        ref_due;
	logic        ref_start;
	logic        mrs_start;

	assign sdram_mode = sys_cfg_q[dsamc_pkg::SYSTEM_CONFIG_SDRAM_BIT];
	assign ref_due    = tick_q && ref_ctl_q[dsamc_pkg::REF_EN_BIT] &&
		(ref_cnt_q == ref_ctl_q[dsamc_pkg::REF_COUNT_LSB +: 11]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_q  <= 11'h000;
			ref_pend_q <= 1'b0;
		end else begin
			if (!ref_ctl_q[dsamc_pkg::REF_EN_BIT] || ref_due)
				ref_cnt_q <= 11'h000;
			else if (tick_q)
				ref_cnt_q <= ref_cnt_q + 11'h001;
			if (ref_due)
				ref_pend_q <= 1'b1;
			else if (ref_start)
				ref_pend_q <= 1'b0;
		end
	end

	// mode register set is requested whenever software enables sdram
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mrs_pend_q <= 1'b0;
		else if (apb_wr && (paddr == dsamc_pkg::OFS_SYSTEM_CONFIG) &&
			pwdata[dsamc_pkg::SYSTEM_CONFIG_SDRAM_BIT])
			mrs_pend_q <= 1'b1;
		else if (mrs_start)
			mrs_pend_q <= 1'b0;
	end

	// ==========================================================
	// access and refresh sequencer
	dsamc_pkg::dsamc_state_t state_q;
	logic [3:0]  cnt_q;
	logic        first_q;
	logic [1:0]  bank_q;
	logic        we_q;
	logic [22:0] word_q;
	logic [31:0] wdata_q;
	logic [3:0]  be_q;
	logic [31:0] cur_ctl;
	logic        step;
	logic [22:0] word_addr;

	assign cur_ctl   = bank_ctl_q[bank_q];
	assign step      = tick_q && (cnt_q == 4'h0);
	// a stale mode-set request left by leaving sdram mode must not stall refresh
	assign ref_start = tick_q && (state_q == dsamc_pkg::ST_IDLE) && !mrs_start && ref_pend_q;
	assign mrs_start = tick_q && (state_q == dsamc_pkg::ST_IDLE) && mrs_pend_q && sdram_mode;

	always_comb begin
		word_addr = mem_byte_addr[24:2];
		case (sys_cfg_q[dsamc_pkg::SYSTEM_CONFIG_WIDTH_LSB +: 2])
			dsamc_pkg::WIDTH_X8:  word_addr = mem_byte_addr[22:0];
			dsamc_pkg::WIDTH_X16: word_addr = mem_byte_addr[23:1];
			default:              word_addr = mem_byte_addr[24:2];
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= dsamc_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			first_q <= 1'b0;
			bank_q  <= 2'h0;
			we_q    <= 1'b0;
			word_q  <= 23'h00_0000;
			wdata_q <= dsamc_pkg::RST_ZERO;
			be_q    <= 4'h0;
		end else begin
			first_q <= 1'b0;
			case (state_q)
				dsamc_pkg::ST_IDLE: begin
					if (mrs_start) begin
						state_q <= dsamc_pkg::ST_MRS;
						cnt_q   <= dsamc_pkg::SD_MRS_TICKS - 4'h1;
						first_q <= 1'b1;
					end else if (ref_start) begin
						// refresh only from idle; new accesses wait behind it
						state_q <= dsamc_pkg::ST_REF;
						cnt_q   <= {1'b0, ref_ctl_q[dsamc_pkg::REF_TCHR_LSB +: 3]};
						first_q <= 1'b1;
						bank_q  <= 2'h0;
					end else if (tick_q && mem_req && !ref_pend_q) begin
						state_q <= dsamc_pkg::ST_ROW;
						cnt_q   <= {3'h0, bank_ctl_q[mem_bank][dsamc_pkg::BANK_TRCD_BIT]};
						first_q <= 1'b1;
						bank_q  <= mem_bank;
						we_q    <= mem_we;
						word_q  <= word_addr;
						wdata_q <= mem_wdata;
						be_q    <= mem_be;
					end
				end
				dsamc_pkg::ST_MRS, dsamc_pkg::ST_REF: begin
					if (step) begin
						state_q <= dsamc_pkg::ST_RPRE;
						// refresh recovery uses bank 0 precharge time
						cnt_q   <= {2'h0, bank_ctl_q[0][dsamc_pkg::BANK_TRP_LSB +: 2]};
						first_q <= 1'b1;
					end else if (tick_q)
						cnt_q <= cnt_q - 4'h1;
				end
				dsamc_pkg::ST_ROW: begin
					if (step) begin
						state_q <= dsamc_pkg::ST_COL;
						if (sdram_mode)
							cnt_q <= we_q ? 4'h0 : dsamc_pkg::SD_CAS_LATENCY - 4'h1;
						else
							cnt_q <= {2'h0, cur_ctl[dsamc_pkg::BANK_TCS_LSB +: 2]};
						first_q <= 1'b1;
					end else if (tick_q)
						cnt_q <= cnt_q - 4'h1;
				end
				dsamc_pkg::ST_COL: begin
					if (step) begin
						state_q <= dsamc_pkg::ST_CPRE;
						cnt_q   <= {3'h0, cur_ctl[dsamc_pkg::BANK_TCP_BIT]};
						first_q <= 1'b1;
					end else if (tick_q)
						cnt_q <= cnt_q - 4'h1;
				end
				dsamc_pkg::ST_CPRE: begin
					if (step) begin
						state_q <= dsamc_pkg::ST_RPRE;
						cnt_q   <= {2'h0, cur_ctl[dsamc_pkg::BANK_TRP_LSB +: 2]};
						first_q <= 1'b1;
					end else if (tick_q)
						cnt_q <= cnt_q - 4'h1;
				end
				dsamc_pkg::ST_RPRE: begin
					if (step)
						state_q <= dsamc_pkg::ST_IDLE;
					else if (tick_q)
						cnt_q <= cnt_q - 4'h1;
				end
				default: begin
					state_q <= dsamc_pkg::ST_IDLE;
					cnt_q   <= 4'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// read data capture and completion
	logic [31:0] din_meta_q;
	logic [31:0] din_sync_q;
	logic [31:0] rdata_q;
	logic        ack_q;
	logic        edo_bank;
	logic        latch_now;
	logic [1:0]  lat_q;

	assign edo_bank  = cur_ctl[dsamc_pkg::BANK_EDO_BIT];
	// pin sample point: fast page at the end of the strobe, edo one clock later
	assign latch_now = !we_q && (sdram_mode || !edo_bank ?
		(state_q == dsamc_pkg::ST_COL && step) :
		(state_q == dsamc_pkg::ST_CPRE && first_q));

	// the latch trails the sample point by the two synchroniser stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_meta_q <= dsamc_pkg::RST_ZERO;
			din_sync_q <= dsamc_pkg::RST_ZERO;
			rdata_q    <= dsamc_pkg::RST_ZERO;
			ack_q      <= 1'b0;
			lat_q      <= 2'h0;
		end else begin
			din_meta_q <= mem_data_in;
			din_sync_q <= din_meta_q;
			lat_q      <= {lat_q[0], latch_now};
			if (lat_q[1])
				rdata_q <= din_sync_q;
			// reads complete when their data is latched
			ack_q <= we_q ? ((state_q == dsamc_pkg::ST_CPRE) && step) : lat_q[1];
		end
	end

	// ==========================================================
	// pin drivers
	logic [21:0] addr_q;
	logic [31:0] dout_q;
	logic        oe_q;
	logic        wen_q;
	logic [3:0]  rs_n_q;
	logic        cs_col_n_q;
	logic [3:0]  sd_cs_n_q;
	logic        sd_ras_n_q;
	logic        sd_cas_n_q;
	logic [3:0]  dqm_q;
	logic [1:0]  can;
	logic        in_row;
	logic        in_col;

	assign can    = cur_ctl[dsamc_pkg::BANK_CAN_LSB +: 2];
	assign in_row = (state_q == dsamc_pkg::ST_ROW);
	assign in_col = (state_q == dsamc_pkg::ST_COL) || (state_q == dsamc_pkg::ST_CPRE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q     <= 22'h00_0000;
			dout_q     <= dsamc_pkg::RST_ZERO;
			oe_q       <= 1'b0;
			wen_q      <= 1'b1;
			rs_n_q     <= 4'hF;
			cs_col_n_q <= 1'b1;
			sd_cs_n_q  <= 4'hF;
			sd_ras_n_q <= 1'b1;
			sd_cas_n_q <= 1'b1;
			dqm_q      <= 4'hF;
		end else begin
			addr_q     <= 22'h00_0000;
			oe_q       <= 1'b0;
			wen_q      <= 1'b1;
			rs_n_q     <= 4'hF;
			cs_col_n_q <= 1'b1;
			sd_cs_n_q  <= 4'hF;
			sd_ras_n_q <= 1'b1;
			sd_cas_n_q <= 1'b1;
			dqm_q      <= 4'hF;
			dout_q     <= wdata_q;
			if (in_row || in_col)
				addr_q[14:0] <= mux_addr(word_q, can, in_row, sdram_mode || word_q[10]);
			if (sdram_mode) begin
				// one-cycle commands, nop in between
				if (state_q == dsamc_pkg::ST_MRS && first_q) begin
					addr_q[14:0] <= dsamc_pkg::SD_MODE_KEY;
					sd_cs_n_q    <= 4'h0;
					sd_ras_n_q   <= 1'b0;
					sd_cas_n_q   <= 1'b0;
					wen_q        <= 1'b0;
				end
				if (state_q == dsamc_pkg::ST_REF && first_q) begin
					sd_cs_n_q  <= 4'h0;
					sd_ras_n_q <= 1'b0;
					sd_cas_n_q <= 1'b0;
				end
				if (in_row && first_q) begin
					sd_cs_n_q[bank_q] <= 1'b0;
					sd_ras_n_q        <= 1'b0;
				end
				if (state_q == dsamc_pkg::ST_COL && first_q) begin
					sd_cs_n_q[bank_q] <= 1'b0;
					sd_cas_n_q        <= 1'b0;
					wen_q             <= !we_q;
				end
				if (state_q == dsamc_pkg::ST_COL)
					dqm_q <= we_q ? ~be_q : 4'h0;
				oe_q <= we_q && (state_q == dsamc_pkg::ST_COL);
			end else begin
				if (state_q == dsamc_pkg::ST_REF) begin
					// cas before ras refresh
					cs_col_n_q <= 1'b0;
					if (!first_q)
						rs_n_q <= 4'h0;
				end
				if (in_row || in_col)
					rs_n_q[bank_q] <= 1'b0;
				if (state_q == dsamc_pkg::ST_COL)
					cs_col_n_q <= 1'b0;
				if (in_col) begin
					wen_q <= !we_q;
					oe_q  <= we_q;
				end
			end
		end
	end

	// ==========================================================
	// outputs
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign mem_rdata           = rdata_q;
	assign mem_ack             = ack_q;
	assign mem_addr_pins       = addr_q;
	assign mem_data_out        = dout_q;
	assign mem_data_oe         = oe_q;
	assign mem_write_en_n      = wen_q;
	assign dram_row_strobe_n   = rs_n_q;
	assign dram_col_strobe_n   = cs_col_n_q;
	assign sdram_clock_out     = sdram_clk_q;
	assign sdram_clock_enable  = cke_q;
	assign sdram_chip_select_n = sd_cs_n_q;
	assign sdram_row_strobe_n  = sd_ras_n_q;
	assign sdram_col_strobe_n  = sd_cas_n_q;
	assign sdram_byte_mask     = dqm_q;
endmodule // dsamc_ctrl

/* rtl/dsamc_pkg.sv */
package dsamc_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [15:0] OFS_SYSTEM_CONFIG  = 16'h3000;
	localparam logic [15:0] OFS_BANK_CONTROL0  = 16'h302C;
	localparam logic [15:0] OFS_REFRESH_EXTIO  = 16'h303C;
	localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
	// ==========================================================
	// system_config fields
	localparam int SYSTEM_CONFIG_SDRAM_BIT = 31;
	localparam int SYSTEM_CONFIG_WIDTH_LSB = 0;
	localparam logic [1:0] WIDTH_X8  = 2'h0;
	localparam logic [1:0] WIDTH_X16 = 2'h1;
	// ==========================================================
	// dram_bank_control fields
	localparam int BANK_EDO_BIT  = 0;
	localparam int BANK_TCS_LSB  = 1;
	localparam int BANK_TCP_BIT  = 3;
	localparam int BANK_TRCD_BIT = 7;
	localparam int BANK_TRP_LSB  = 8;
	localparam int BANK_CAN_LSB  = 30;
	// ==========================================================
	// refresh_extio_control fields
	localparam int REF_EN_BIT    = 16;
	localparam int REF_TCHR_LSB  = 17;
	localparam int REF_COUNT_LSB = 21;
	// ==========================================================
	// sdram mode key: cas latency 2, burst length 1, sequential
	localparam logic [14:0] SD_MODE_KEY    = 15'h0020;
	localparam logic [3:0]  SD_CAS_LATENCY = 4'h2;
	localparam logic [3:0]  SD_MRS_TICKS   = 4'h2;
	// ==========================================================
	// controller states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_MRS  = 7'b000_0010,
		ST_ROW  = 7'b000_0100,
		ST_COL  = 7'b000_1000,
		ST_CPRE = 7'b001_0000,
		ST_RPRE = 7'b010_0000,
		ST_REF  = 7'b100_0000
	} dsamc_state_t;
endpackage

/* testbench/dsamc_asserts.sv */
`timescale 1ns/1ps
module dsamc_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// memory request
	input wire logic        mem_req,
	input wire logic        mem_ack,
	input wire logic [3:0]  mem_be,
	// memory pins
	input wire logic [21:0] mem_addr_pins,
	input wire logic        mem_write_en_n,
	input wire logic [3:0]  dram_row_strobe_n,
	input wire logic        dram_col_strobe_n,
	input wire logic        sdram_clock_out,
	input wire logic        sdram_clock_enable,
	input wire logic [3:0]  sdram_chip_select_n,
	input wire logic        sdram_row_strobe_n,
	input wire logic        sdram_col_strobe_n,
	input wire logic [3:0]  sdram_byte_mask
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// sdram command sequences
	sequence s_sel; sdram_chip_select_n != 4'hF; endsequence
	sequence s_mrs;
		sdram_chip_select_n == 4'h0 && !sdram_row_strobe_n && !sdram_col_strobe_n
			&& !mem_write_en_n;
	endsequence
	sequence s_col; s_sel ##0 (sdram_row_strobe_n && !sdram_col_strobe_n); endsequence
	sequence s_wcol; s_col ##0 !mem_write_en_n; endsequence
	// ==========================================================
	// properties
	property p_rdy; psel && !penable |=> pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_cke; $past(presetn) |-> sdram_clock_enable; endproperty
	property p_clk; $past(presetn, 2) |-> sdram_clock_out != $past(sdram_clock_out); endproperty
	property p_hi; mem_addr_pins[21:15] == 7'h00; endproperty
	property p_mrs; s_mrs |-> mem_addr_pins[14:0] == dsamc_pkg::SD_MODE_KEY; endproperty
	property p_ap; s_col |-> mem_addr_pins[10]; endproperty
	property p_dqm; s_wcol |-> sdram_byte_mask == ~mem_be; endproperty
	property p_cbr;
		$fell(dram_col_strobe_n) && dram_row_strobe_n == 4'hF
			|-> ##[1:2] dram_row_strobe_n == 4'h0;
	endproperty
	property p_ack; $rose(mem_req) |-> ##[2:200] mem_ack; endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_cke: assert property (p_cke) else $error("clock enable low");
	a_clk: assert property (p_clk) else $error("sdram clock stuck");
	a_hi: assert property (p_hi) else $error("upper pins not zero");
	a_mrs: assert property (p_mrs) else $error("bad mode key");
	a_ap: assert property (p_ap) else $error("auto precharge low");
	a_dqm: assert property (p_dqm) else $error("bad byte mask");
	a_cbr: assert property (p_cbr) else $error("refresh rows not low");
	a_ack: assert property (p_ack) else $error("request not acked");
endmodule // dsamc_asserts

bind dsamc_ctrl dsamc_asserts i_chk (.*);

/* testbench/dsamc_dram_model.sv */
`timescale 1ns/1ps
module dsamc_dram_model (
	// clock
	input  wire logic        pclk,
	// strobes and pins
	input  wire logic [3:0]  ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [14:0] pins,
	// data
	input  wire logic [31:0] wd,
	output logic      [31:0] rd
);
	logic [31:0] mem [0:255];
	logic [14:0] row_q  = 15'h0000;
	logic [14:0] col_q  = 15'h0000;
	logic [31:0] last_q = 32'h0000_0000;
	logic [3:0]  ras_p  = 4'hF;
	logic        seen_q = 1'b0;
	wire         open   = ras_n != 4'hF;
	wire  [14:0] col    = cas_n ? col_q : pins;
	// data held while row stays open after the column strobe rises
	assign rd = (open && (!cas_n || seen_q)) ? mem[{row_q[3:0], col[3:0]}] : ~last_q;
	always @(posedge pclk) begin
		if (ras_p == 4'hF && open && cas_n)
			row_q <= pins;
		if (open && !cas_n)
			col_q <= pins;
		if (open && !cas_n && !we_n)
			mem[{row_q[3:0], pins[3:0]}] <= wd;
		seen_q <= open && (seen_q || !cas_n);
		last_q <= rd;
		ras_p <= ras_n;
	end
endmodule // dsamc_dram_model

/* testbench/tb_dram_sdram_address_mux_ctrl.sv */
`timescale 1ns/1ps
module tb_dram_sdram_address_mux_ctrl;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, mem_req, mem_we;
	logic [15:0] paddr;
	logic [31:0] pwdata, mem_wdata, v;
	logic [1:0]  mem_bank, wid;
	logic [24:0] mem_byte_addr;
	logic [3:0]  mem_be;
	wire  [31:0] prdata, mem_rdata, mem_data_in, mem_data_out;
	wire         pready, pslverr, mem_ack, mem_data_oe, mem_write_en_n, dram_col_strobe_n;
	wire         sdram_clock_out, sdram_clock_enable, sdram_row_strobe_n, sdram_col_strobe_n;
	wire  [3:0]  dram_row_strobe_n, sdram_chip_select_n, sdram_byte_mask;
	wire  [21:0] mem_addr_pins;
	logic [32:0] aq[$], dq[$];
	logic [29:0] xq[$], x;
	logic [14:0] colx;
	logic [1:0]  can_of [4];
	logic [3:0]  ras_p = 4'hF;
	logic        cas_p = 1'b1;
	logic        sd_on = 1'b0;
	int          errors = 0;
	int          comparisons = 0;

	dsamc_ctrl i_dut (.*);
	dsamc_dram_model i_mem (.pclk(pclk), .ras_n(dram_row_strobe_n), .cas_n(dram_col_strobe_n),
		.we_n(mem_write_en_n), .pins(mem_addr_pins[14:0]), .wd(mem_data_out), .rd(mem_data_in));

	always #20 pclk = ~pclk;

	// ==========================================================
	// helpers
	function automatic logic [29:0] mux(input logic [24:0] b, input logic [1:0] c);
		logic [22:0] a;
		a = (wid == 2'h0) ? b[22:0] : (wid == 2'h1) ? b[23:1] : b[24:2];
		return {15'(a >> (8 + c)), 4'(a[22:19] >> c), a[10:0]};
	endfunction
	task automatic check(input logic [32:0] s, input logic [32:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_sig(input int m);
		for (int i = 0; i < 400; i++) begin
			@(posedge pclk);
			if ((m ? mem_ack : pready) === 1'b1)
				return;
		end
		errors++;
		end_sim;
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			aq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		wait_sig(0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mem_op(input logic w, input logic [1:0] b, input logic [24:0] ad,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge pclk);
		mem_req <= 1'b1;
		mem_we <= w;
		mem_bank <= b;
		mem_byte_addr <= ad;
		mem_wdata <= d;
		mem_be <= be;
		if (!sd_on)
			xq.push_back(mux(ad, can_of[b]));
		if (!w)
			dq.push_back({1'b0, d});
		wait_sig(1);
		mem_req <= 1'b0;
	endtask
	task automatic wr_rd(input logic [1:0] b);
		logic [24:0] ad;
		logic [31:0] d;
		ad = 25'($urandom);
		d = $urandom;
		mem_op(1'b1, b, ad, d, 4'hF);
		mem_op(1'b0, b, ad, d, 4'hF);
	endtask

	// ==========================================================
	// output watcher
	always @(posedge pclk) begin
		if (!sd_on && ras_p == 4'hF && dram_row_strobe_n != 4'hF && dram_col_strobe_n) begin
			x = xq.pop_front();
			colx = x[14:0];
			check(33'(mem_addr_pins[14:0]), 33'(x[29:15]));
		end
		if (!sd_on && cas_p && !dram_col_strobe_n && dram_row_strobe_n != 4'hF) begin
			check(33'(mem_addr_pins[14:0]), 33'(colx));
			check(33'(mem_data_oe), 33'(mem_we));
		end
		if (mem_ack && !mem_we)
			check({1'b0, mem_rdata}, dq.pop_front());
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, aq.pop_front());
		ras_p = dram_row_strobe_n;
		cas_p = dram_col_strobe_n;
	end

	// ==========================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, mem_req, mem_we} = 5'h00;
		{paddr, pwdata, mem_wdata, mem_bank, mem_byte_addr, mem_be} = '0;
		wid = 2'h2;
		v = $urandom(30);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, dsamc_pkg::OFS_SYSTEM_CONFIG, 32'h0000_0000, 33'h0_0000_0000);
		apb(1'b0, dsamc_pkg::OFS_BANK_CONTROL0, 32'h0000_0000, 33'h0_0000_0000);
		apb(1'b0, dsamc_pkg::OFS_REFRESH_EXTIO, 32'h0000_0000, 33'h0_0000_0000);
		apb(1'b0, 16'h3100, 32'h0000_0000, 33'h1_0000_0000);
		$display("test reset and unmapped done");
		apb(1'b1, dsamc_pkg::OFS_SYSTEM_CONFIG, {30'h0000_0000, wid}, 33'h0_0000_0000);
		for (int i = 0; i < 8; i++) begin
			v = $urandom;
			v = {2'(i % 4), 20'h0_0000, v[5:4], v[3], 3'h1, v[2], v[1:0], 1'(i / 4)};
			apb(1'b1, dsamc_pkg::OFS_BANK_CONTROL0 + 16'(4 * (i % 4)), v, 33'h0_0000_0000);
			apb(1'b0, dsamc_pkg::OFS_BANK_CONTROL0 + 16'(4 * (i % 4)), 32'h0000_0000,
				{1'b0, v});
			can_of[i % 4] = 2'(i % 4);
			wr_rd(2'(i % 4));
		end
		$display("test column widths and timing done");
		for (int w = 0; w < 2; w++) begin
			wid = 2'(w);
			apb(1'b1, dsamc_pkg::OFS_SYSTEM_CONFIG, {30'h0000_0000, wid}, 33'h0_0000_0000);
			wr_rd(2'h0);
		end
		$display("test bus width scaling done");
		apb(1'b1, dsamc_pkg::OFS_REFRESH_EXTIO, {11'h028, 1'b0, 3'h0, 1'b1, 16'h0000},
			33'h0_0000_0000);
		for (int i = 0; i < 10; i++)
			wr_rd(2'(i % 4));
		$display("test refresh arbitration done");
		sd_on = 1'b1;
		apb(1'b1, dsamc_pkg::OFS_SYSTEM_CONFIG, 32'h8000_0002, 33'h0_0000_0000);
		repeat (20) @(posedge pclk);
		mem_op(1'b1, 2'h0, 25'($urandom), $urandom, 4'h5);
		repeat (10) @(posedge pclk);
		$display("test sdram mode done");
		end_sim;
	end
endmodule // tb_dram_sdram_address_mux_ctrl
